// File: shared/pic_pkg.sv
/*
 * Constants and carrier types for the four-channel input-capture block.
 * Assumes a 32-bit word bus with byte addresses and one PWM group clock.
 */
package pic_pkg;

    localparam int NCH = 4;
    localparam int CW  = 16;
    localparam int AW  = 8;
    localparam int DW  = 32;

    // Byte offsets
    localparam logic [7:0] OFS_COMPAT  = 8'h3C;
    localparam logic [7:0] OFS_CTRL01  = 8'h50;
    localparam logic [7:0] OFS_CTRL23  = 8'h54;
    localparam logic [7:0] OFS_RISE0   = 8'h58;
    localparam logic [7:0] OFS_FALL0   = 8'h5C;
    localparam logic [7:0] OFS_STEP    = 8'h08;
    localparam logic [7:0] OFS_PATH_EN = 8'h78;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h90;

    // Field positions inside one channel lane
    localparam int B_INV      = 0;
    localparam int B_RIE      = 1;
    localparam int B_FIE      = 2;
    localparam int B_CAPON    = 3;
    localparam int B_IRQF     = 4;
    localparam int B_RISE_IND = 6;
    localparam int B_FALL_IND = 7;
    localparam int LANE_W     = 8;
    localparam int LANE_HI    = 16;

    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] RST_LATCH = 16'h0000;
    localparam logic [3:0]  RST_NIB   = 4'h0;

    typedef struct packed {
        logic            rd;
        logic            wr;
        logic [AW-1:0]   addr;
        logic [DW-1:0]   wdata;
    } pic_bus_req_t;

    typedef struct packed {
        logic cap_on;
        logic fall_ie;
        logic rise_ie;
        logic invert;
    } pic_cfg_t;

    typedef struct packed {
        logic fall_ind;
        logic rise_ind;
        logic irq_flag;
    } pic_flag_t;

endpackage

// File: design/pic_capture.sv
/*
 * Four-channel input capture: pin sync, edge detect, counter latches,
 * latched indicators, capture interrupt flags and register port.
 * Assumes pwm_count is on clk; cap_pin is asynchronous to clk.
 */
// Added by the designer: strobed register access.
// Function
// - Falling edge latches counter, sets falling indicator
// - Rising edge latches counter, sets rising indicator
// - Indicator cleared by writing the selected polarity
// - Enabled edge sets channel capture interrupt flag
// - Writing one clears interrupt flag, zero ignored
// - Capture off: no latch update, no interrupt
// - Falling enable lets falling edge request interrupt
// - Rising enable lets rising edge request interrupt
// - Inverter swaps rising and falling edges
// - Lane layout: bits 7..0 and 23..16
// - Channels 2 and 3 at second control word
// - Control words reset to all zeros
// - Compat bit selects indicator clear polarity
// - Read-only 16-bit latches, step of eight
// - Input path off forces input to zero
`timescale 1ns/100ps
module pic_capture
    import pic_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           arst_n,
    input  wire pic_bus_req_t   bus_req,
    input  wire logic [NCH-1:0] cap_pin,
    input  wire logic [CW-1:0]  pwm_count,
    output wire logic [DW-1:0]  rdata,
    output wire logic           irq
);

    function automatic logic [7:0] ctrl_ofs(input logic [1:0] ch);
        ctrl_ofs = ch[1] ? OFS_CTRL23 : OFS_CTRL01;
    endfunction

    function automatic logic [7:0] latch_ofs(input logic [1:0] ch,
                                             input logic       fall);
        latch_ofs = (fall ? OFS_FALL0 : OFS_RISE0)
                  + 8'({6'h00, ch} * OFS_STEP);
    endfunction

    function automatic logic [7:0] lane_of(input logic [31:0] w,
                                           input logic [1:0]  ch);
        lane_of = ch[0] ? w[LANE_HI +: LANE_W] : w[0 +: LANE_W];
    endfunction

    function automatic logic [7:0] pack_lane(input pic_cfg_t  c,
                                             input pic_flag_t f);
        pack_lane = {f.fall_ind, f.rise_ind, 1'b0, f.irq_flag,
                     c.cap_on, c.fall_ie, c.rise_ie, c.invert};
    endfunction

    // Synchroniser and edge state
    logic [NCH-1:0] sync1_r;
    logic [NCH-1:0] sync2_r;
    logic [NCH-1:0] prev_r;
    logic [NCH-1:0] prev_nxt;
    logic [NCH-1:0] proc_lvl;
    logic [NCH-1:0] rise_ev;
    logic [NCH-1:0] fall_ev;

    // Configuration state
    pic_cfg_t       cfg_r    [NCH];
    pic_cfg_t       cfg_nxt  [NCH];
    logic           compat_r;
    logic           compat_nxt;
    logic [NCH-1:0] path_en_r;
    logic [NCH-1:0] path_en_nxt;
    logic [NCH-1:0] mask_r;
    logic [NCH-1:0] mask_nxt;

    // Capture state
    pic_flag_t      flag_r   [NCH];
    pic_flag_t      flag_nxt [NCH];
    logic [CW-1:0]  rise_lat_r   [NCH];
    logic [CW-1:0]  rise_lat_nxt [NCH];
    logic [CW-1:0]  fall_lat_r   [NCH];
    logic [CW-1:0]  fall_lat_nxt [NCH];

    // Bus answer state
    logic [DW-1:0]  rdata_r;
    logic [DW-1:0]  rdata_nxt;
    logic           irq_r;
    logic           irq_nxt;
    logic [NCH-1:0] wr_ctrl;
    logic [NCH-1:0] irqf_nxt;
    logic [7:0]     wr_lane  [NCH];

    assign rdata = rdata_r;
    assign irq   = irq_r;

    // Edge detection on synchronised, gated, inverted input
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            proc_lvl[i] = (sync2_r[i] & path_en_r[i])
                        ^ cfg_r[i].invert;
        end
        rise_ev  = proc_lvl & ~prev_r;
        fall_ev  = ~proc_lvl & prev_r;
        prev_nxt = proc_lvl;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= RST_NIB;
            sync2_r <= RST_NIB;
            prev_r  <= RST_NIB;
        end else begin
            sync1_r <= cap_pin;
            sync2_r <= sync1_r;
            prev_r  <= prev_nxt;
        end
    end

    // Configuration writes
    always_comb begin
        compat_nxt  = compat_r;
        path_en_nxt = path_en_r;
        mask_nxt    = mask_r;
        for (int i = 0; i < NCH; i++) begin
            wr_ctrl[i] = bus_req.wr && bus_req.addr == ctrl_ofs(2'(i));
            wr_lane[i] = lane_of(bus_req.wdata, 2'(i));
            cfg_nxt[i] = cfg_r[i];
            if (wr_ctrl[i]) begin
                cfg_nxt[i].cap_on  = wr_lane[i][B_CAPON];
                cfg_nxt[i].fall_ie = wr_lane[i][B_FIE];
                cfg_nxt[i].rise_ie = wr_lane[i][B_RIE];
                cfg_nxt[i].invert  = wr_lane[i][B_INV];
            end
        end
        if (bus_req.wr && bus_req.addr == OFS_COMPAT) begin
            compat_nxt = bus_req.wdata[0];
        end
        if (bus_req.wr && bus_req.addr == OFS_PATH_EN) begin
            path_en_nxt = bus_req.wdata[NCH-1:0];
        end
        if (bus_req.wr && bus_req.addr == OFS_IRQ_MSK) begin
            mask_nxt = bus_req.wdata[NCH-1:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_r[i] <= pic_cfg_t'(RST_NIB);
            end
            compat_r  <= 1'b0;
            path_en_r <= RST_NIB;
            mask_r    <= RST_NIB;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
            compat_r  <= compat_nxt;
            path_en_r <= path_en_nxt;
            mask_r    <= mask_nxt;
        end
    end

    // Latches, indicators and interrupt flags; a set beats a clear
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            flag_nxt[i]     = flag_r[i];
            rise_lat_nxt[i] = rise_lat_r[i];
            fall_lat_nxt[i] = fall_lat_r[i];
            if (wr_ctrl[i]) begin
                if (wr_lane[i][B_FALL_IND] == compat_r)
                    flag_nxt[i].fall_ind = 1'b0;
                if (wr_lane[i][B_RISE_IND] == compat_r)
                    flag_nxt[i].rise_ind = 1'b0;
                if (wr_lane[i][B_IRQF])
                    flag_nxt[i].irq_flag = 1'b0;
            end
            if (cfg_r[i].cap_on) begin
                if (fall_ev[i]) begin
                    fall_lat_nxt[i]      = pwm_count;
                    flag_nxt[i].fall_ind = 1'b1;
                end
                if (rise_ev[i]) begin
                    rise_lat_nxt[i]      = pwm_count;
                    flag_nxt[i].rise_ind = 1'b1;
                end
                if ((fall_ev[i] && cfg_r[i].fall_ie)
                    || (rise_ev[i] && cfg_r[i].rise_ie))
                    flag_nxt[i].irq_flag = 1'b1;
            end
            irqf_nxt[i] = flag_nxt[i].irq_flag;
        end
        irq_nxt = |(irqf_nxt & mask_nxt);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                flag_r[i]     <= pic_flag_t'(3'h0);
                rise_lat_r[i] <= RST_LATCH;
                fall_lat_r[i] <= RST_LATCH;
            end
            irq_r <= 1'b0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                flag_r[i]     <= flag_nxt[i];
                rise_lat_r[i] <= rise_lat_nxt[i];
                fall_lat_r[i] <= fall_lat_nxt[i];
            end
            irq_r <= irq_nxt;
        end
    end

    // Read answer, one cycle after the strobe only
    always_comb begin
        rdata_nxt = RST_WORD;
        if (bus_req.rd) begin
            for (int i = 0; i < NCH; i++) begin
                if (bus_req.addr == ctrl_ofs(2'(i))) begin
                    if (i % 2 == 1)
                        rdata_nxt[LANE_HI +: LANE_W] =
                            pack_lane(cfg_r[i], flag_r[i]);
                    else
                        rdata_nxt[0 +: LANE_W] =
                            pack_lane(cfg_r[i], flag_r[i]);
                end
                if (bus_req.addr == latch_ofs(2'(i), 1'b0))
                    rdata_nxt = {16'h0000, rise_lat_r[i]};
                if (bus_req.addr == latch_ofs(2'(i), 1'b1))
                    rdata_nxt = {16'h0000, fall_lat_r[i]};
            end
            if (bus_req.addr == OFS_COMPAT)
                rdata_nxt = {31'h0000_0000, compat_r};
            if (bus_req.addr == OFS_PATH_EN)
                rdata_nxt = {28'h000_0000, path_en_r};
            if (bus_req.addr == OFS_IRQ_MSK)
                rdata_nxt = {28'h000_0000, mask_r};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= RST_WORD;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_fall_latch: assert property (
        fall_ev[0] && cfg_r[0].cap_on |=>
            fall_lat_r[0] == $past(pwm_count) && flag_r[0].fall_ind)
        else $error("falling latch not captured");

    chk_rise_latch: assert property (
        rise_ev[1] && cfg_r[1].cap_on |=>
            rise_lat_r[1] == $past(pwm_count) && flag_r[1].rise_ind)
        else $error("rising latch not captured");

    chk_ind_clear_pol: assert property (
        bus_req.wr && bus_req.addr == OFS_CTRL01
        && bus_req.wdata[B_FALL_IND] == compat_r && !fall_ev[0] |=>
            !flag_r[0].fall_ind)
        else $error("indicator not cleared by selected polarity");

    chk_ind_keep: assert property (
        flag_r[0].rise_ind && bus_req.wr && bus_req.addr == OFS_CTRL01
        && bus_req.wdata[B_RISE_IND] != compat_r |=> flag_r[0].rise_ind)
        else $error("indicator cleared by wrong polarity");

    chk_irq_set: assert property (
        rise_ev[2] && cfg_r[2].cap_on && cfg_r[2].rise_ie |=>
            flag_r[2].irq_flag)
        else $error("capture flag not set on rising edge");

    chk_irq_w1c_zero: assert property (
        flag_r[0].irq_flag && bus_req.wr && bus_req.addr == OFS_CTRL01
        && !bus_req.wdata[B_IRQF] |=> flag_r[0].irq_flag)
        else $error("writing zero changed capture flag");

    chk_cap_off: assert property (
        !cfg_r[3].cap_on && !flag_r[3].irq_flag
        && !(wr_ctrl[3]) |=> $stable(rise_lat_r[3])
            && $stable(fall_lat_r[3]) && !flag_r[3].irq_flag)
        else $error("disabled channel updated");

    chk_path_gate: assert property (
        (!path_en_r[0] && !cfg_r[0].invert)[*2] |-> !rise_ev[0])
        else $error("gated input produced an edge");

    chk_single_event: assert property (
        rise_ev[0] |=> !rise_ev[0] ##1 !rise_ev[0] || fall_ev[0])
        else $error("one edge gave two events");

    chk_reserved_zero: assert property (
        bus_req.rd && bus_req.addr == OFS_CTRL23 |=>
            rdata_r[31:24] == 8'h00 && rdata_r[15:8] == 8'h00
            && !rdata_r[5] && !rdata_r[21])
        else $error("reserved bits read nonzero");

    chk_irq_out: assert property (
        irq_r == |({flag_r[3].irq_flag, flag_r[2].irq_flag,
                    flag_r[1].irq_flag, flag_r[0].irq_flag} & mask_r))
        else $error("interrupt output disagrees with flags");

endmodule

// File: verif/pic_pin_model.sv
/*
 * Far-side pin model: moves each capture pin to the requested level.
 * Assumes the capture block clock; slow delays a change two cycles.
 */
`timescale 1ns/100ps
module pic_pin_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] want,
    input  wire logic       slow,
    output logic      [3:0] cap_pin
);
    logic [1:0] dly_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_pin <= 4'h0;
            dly_r   <= 2'h0;
        end else if (want == cap_pin) begin
            dly_r <= 2'h0;
        end else if (slow && dly_r != 2'h2) begin
            dly_r <= dly_r + 2'h1;
        end else begin
            cap_pin <= want;
        end
    end
endmodule

// File: verif/tb_pic_capture.sv
/*
 * Self-checking bench for the four-channel input capture block.
 * Assumes a 100 MHz clock and the pin model on the capture inputs.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end end
module tb_pic_capture
    import pic_pkg::*;
;
    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    pic_bus_req_t  bus_req = '0;
    logic [3:0]    want = 4'h0;
    logic          slow = 1'b0;
    logic [CW-1:0] pwm_count = 16'h0000;
    logic [3:0]    cap_pin;
    logic [DW-1:0] rdata;
    logic          irq;
    logic [31:0]   seed = 32'h0001_6ED7;
    int            num_errors = 0;
    int            total_checks = 0;
    int            cyc = 0;

    pic_capture dut_u (
        .clk       (clk),
        .arst_n    (arst_n),
        .bus_req   (bus_req),
        .cap_pin   (cap_pin),
        .pwm_count (pwm_count),
        .rdata     (rdata),
        .irq       (irq)
    );

    pic_pin_model pin_u (
        .clk     (clk),
        .arst_n  (arst_n),
        .want    (want),
        .slow    (slow),
        .cap_pin (cap_pin)
    );

    always #5 clk = ~clk;

    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] ln(input logic [3:0] h,
                                      input logic       fe, re, v);
        return {h[3:2], 1'b0, h[1:0], fe, re, v};
    endfunction

    function automatic logic [31:0] wd(input int ch, input logic [7:0] v);
        return ch[0] ? {8'h00, v, 16'h0000} : {24'h00_0000, v};
    endfunction

    function automatic logic [7:0] ctl(input int ch);
        return (ch < 2) ? OFS_CTRL01 : OFS_CTRL23;
    endfunction

    function automatic logic [7:0] lat(input int ch, input logic fall);
        return OFS_RISE0 + 8'(8 * ch) + (fall ? 8'h04 : 8'h00);
    endfunction

    task automatic wait_c(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge clk);
        bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask

    task automatic put(input int ch, input logic [7:0] v);
        wr(ctl(ch), wd(ch, v));
    endtask

    task automatic cap_ch(input int ch);
        logic [31:0] t;
        logic        fe, re, v, ir;
        t = rnd();
        {fe, re, v} = t[2:0];
        @(posedge clk);
        slow <= ch[0];
        put(ch, ln(4'h0, fe, re, v));
        wait_c(6);
        put(ch, ln(4'h1, fe, re, v));
        pwm_count <= t[31:16];
        want[ch] <= 1'b1;
        wait_c(8);
        ir = v ? fe : re;
        rd(lat(ch, v), {16'h0000, t[31:16]}, "latch a");
        rd(ctl(ch), wd(ch, ln({v, !v, ir, 1'b1}, fe, re, v)), "ctl a");
        `CHK("irq a", ir, irq)
        @(posedge clk);
        pwm_count <= t[15:0];
        want[ch] <= 1'b0;
        wait_c(8);
        ir = ir | (v ? re : fe);
        rd(lat(ch, !v), {16'h0000, t[15:0]}, "latch b");
        rd(ctl(ch), wd(ch, ln({2'h3, ir, 1'b1}, fe, re, v)), "ctl b");
        put(ch, ln(4'hF, fe, re, v));
        rd(ctl(ch), wd(ch, ln(4'h1, fe, re, v)), "clr");
        `CHK("irq c", 1'b0, irq)
        put(ch, ln(4'h0, fe, re, v));
        wr(lat(ch, v), 32'hFFFF_FFFF);
        pwm_count <= ~t[15:0];
        want[ch] <= 1'b1;
        wait_c(8);
        rd(lat(ch, v), {16'h0000, t[31:16]}, "latch off");
        rd(ctl(ch), wd(ch, ln(4'h0, fe, re, v)), "ctl off");
        @(posedge clk);
        want[ch] <= 1'b0;
        wait_c(8);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_CTRL01, RST_WORD, "rst01");
        rd(OFS_CTRL23, RST_WORD, "rst23");
        for (int c = 0; c < NCH; c++) begin
            rd(lat(c, 1'b0), RST_WORD, "rst rise");
            rd(lat(c, 1'b1), RST_WORD, "rst fall");
        end
        wr(OFS_CTRL01, 32'hFFF7_FFF7);
        rd(OFS_CTRL01, 32'h0007_0007, "rsvd01");
        wr(OFS_CTRL23, 32'hFFF7_FFF7);
        rd(OFS_CTRL23, 32'h0007_0007, "rsvd23");
        rd(8'hFC, RST_WORD, "unmapped");
        wr(OFS_PATH_EN, 32'h0000_000F);
        wr(OFS_IRQ_MSK, 32'h0000_000F);
        wr(OFS_COMPAT, 32'h0000_0001);
        rd(OFS_COMPAT, 32'h0000_0001, "compat");
        for (int c = 0; c < NCH; c++) begin
            cap_ch(c);
        end
        wr(OFS_COMPAT, 32'h0000_0000);
        put(0, 8'h08);
        want[0] <= 1'b1;
        wait_c(8);
        want[0] <= 1'b0;
        wait_c(8);
        put(0, 8'hC8);
        rd(OFS_CTRL01, 32'h0000_00C8, "keep0");
        put(0, 8'h08);
        rd(OFS_CTRL01, 32'h0000_0008, "clr0");
        wr(OFS_PATH_EN, 32'h0000_000E);
        want[0] <= 1'b1;
        wait_c(8);
        rd(OFS_CTRL01, 32'h0000_0008, "path off");
        @(posedge clk);
        want[0] <= 1'b0;
        wait_c(8);
        wr(OFS_PATH_EN, 32'h0000_000F);
        put(0, 8'h0A);
        wr(OFS_IRQ_MSK, 32'h0000_0000);
        want[0] <= 1'b1;
        wait_c(8);
        @(negedge clk);
        `CHK("irq masked", 1'b0, irq)
        wr(OFS_IRQ_MSK, 32'h0000_0001);
        wait_c(2);
        @(negedge clk);
        `CHK("irq unmasked", 1'b1, irq)
        end_sim();
    end
endmodule
